// file: rtl/time_sync_pkg.sv
// Purpose: shared constants and types for the time synchronisation source selector
// Assumes: 125 MHz clock, time held as seconds since an epoch
// Notes:   mode codes follow the selectable mode numbering 1..14
package time_sync_pkg;

    localparam int          ClockHz      = 125_000_000;
    localparam int          ModeCount    = 14;
    localparam logic [3:0]  ModeInternal = 4'h1;
    localparam logic [3:0]  ModePulse    = 4'h6;
    localparam logic [3:0]  ModeMasterLo = 4'h8;
    localparam logic [3:0]  ModeMasterHi = 4'he;
    localparam logic [3:0]  ModeIrig     = 4'h3;
    localparam logic [3:0]  ModeDcf      = 4'h4;
    localparam int          SwitchTimeMs = 1000;
    localparam int          SwitchCycles = ClockHz / 1000 * SwitchTimeMs;
    localparam int          OffsetLimit  = 1439;
    localparam int          MinTolMin    = 2;
    localparam logic [31:0] SecPerMin    = 32'h0000_003c;
    localparam logic [5:0]  HalfMinute   = 6'h1e;

    typedef logic [31:0] seconds_t;

    typedef struct packed {
        logic     valid;
        seconds_t secs;
    } time_word_t;

    typedef struct packed {
        logic     jumpStart;
        logic     jumpEnd;
        seconds_t stamp;
    } jump_event_t;

    typedef enum logic [1:0] {
        SyncLost  = 2'b00,
        SyncWait  = 2'b01,
        SyncGood  = 2'b11
    } sync_state_t;

endpackage

// file: rtl/time_sync_source_selector.sv
// Purpose: internal time-of-day counter disciplined from one selected source
// Assumes: source decoders deliver whole decoded times as one-cycle valid words
// Notes:   time is a seconds counter; calendar split is done outside this block
//
// Functional notes
// RULE1 - fourteen modes: seven single sources, each with a timing-master variant
// RULE2 - battery RTC loads the internal clock first at power-up or power failure
// RULE3 - internal mode runs from the RTC only; RTC accepts a manual write
// RULE4 - external mode accepts only its source; otherwise clock free-runs
// RULE5 - radio time only applied once fully decoded
// RULE6 - IRIG B year comes from the manually written year setting
// RULE7 - minute pulse rounds seconds to whole minute, above 30 goes forward
// RULE8 - every minute-pulse edge applied directly, no filtering
// RULE9 - modes 8 to 14 follow master, local source only while master absent; mode 13 never applies the minute pulse, only the master
// RULE10 - signed offset in minutes, limited to plus or minus 1439
// RULE11 - fault alarm once synchronisation absent longer than tolerance
// RULE12 - configuring party sets tolerance to two minutes or more
// RULE13 - mode change switches within one second and counts as sync loss
// RULE14 - offset or year change reports jump start then jump end
// RULE15 - outage beyond tolerance raises jump start, resync raises jump end
// RULE16 - free-running seconds counter, atomic overwrite, tolerance restarts
module time_sync_source_selector (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        clockEnable,
    // configuration
    input  wire logic [3:0]                  syncMode,
    input  wire logic signed [11:0]          offsetMin,
    input  wire logic [31:0]                 yearBaseSecs,
    input  wire logic [15:0]                 toleranceSec,
    input  wire logic                        powerGood,
    // battery rtc
    input  wire time_sync_pkg::time_word_t   rtcTime,
    input  wire time_sync_pkg::time_word_t   manualTime,
    // external sources, indexed by mode 2..7
    input  wire time_sync_pkg::time_word_t   srcTime [2:7],
    input  wire logic                        minutePulse,
    input  wire time_sync_pkg::time_word_t   masterTime,
    // outputs
    output time_sync_pkg::seconds_t          systemTime,
    output time_sync_pkg::time_word_t        rtcWrite,
    output logic                             syncFault,
    output logic                             synced,
    output time_sync_pkg::jump_event_t       jumpEvent
);

    localparam int PrescaleMax = time_sync_pkg::ClockHz - 1;

    logic [26:0]                 prescale;
    logic                        secTick;
    logic [1:0]                  pulseSync;
    logic                        pulseLast;
    logic [3:0]                  modeSeen;
    logic [26:0]                 switchCount;
    logic                        switching;
    logic                        modeKnown;
    logic [15:0]                 silentSec;
    logic                        powerLast;
    logic signed [11:0]          offsetSeen;
    logic [31:0]                 yearSeen;
    logic                        jumpPending;
    time_sync_pkg::seconds_t     jumpNewTime;
    time_sync_pkg::sync_state_t  syncState;
    time_sync_pkg::time_word_t   localWord;
    time_sync_pkg::time_word_t   next_update;
    logic                        pulseEdge;
    logic                        cfgChange;

    // clamp and apply the signed minute offset
    function automatic time_sync_pkg::seconds_t withOffset(input time_sync_pkg::seconds_t t,
                                                          input logic signed [11:0] m);
        logic signed [11:0] c;
        c = m;
        if (m > 12'(time_sync_pkg::OffsetLimit)) c = 12'(time_sync_pkg::OffsetLimit);
        if (m < -12'(time_sync_pkg::OffsetLimit)) c = -12'(time_sync_pkg::OffsetLimit);
        return t + 32'(signed'(c) * signed'(time_sync_pkg::SecPerMin));
    endfunction

    function automatic logic isRadio(input logic [3:0] m);
        return m == time_sync_pkg::ModeDcf || m == time_sync_pkg::ModeIrig;
    endfunction

    assign pulseEdge = pulseSync[1] & ~pulseLast;
    assign cfgChange = (offsetMin != offsetSeen) || (yearBaseSecs != yearSeen);

    // choose the single accepted source for this cycle
    always_comb begin
        logic [3:0] local_m;
        local_m = (syncMode >= time_sync_pkg::ModeMasterLo) ? 4'(syncMode - 4'h7) : syncMode;
        localWord = '{valid: 1'b0, secs: '0};
        if (local_m == time_sync_pkg::ModeInternal) begin
            localWord = rtcTime; // RULE3
        end else if (local_m >= 4'h2 && local_m <= 4'h7 && local_m != time_sync_pkg::ModePulse)
        begin
            localWord = srcTime[local_m]; // RULE4 RULE5
            if (local_m == time_sync_pkg::ModeIrig)
                localWord.secs = srcTime[local_m].secs + yearBaseSecs; // RULE6
            if (isRadio(local_m))
                localWord.secs = withOffset(localWord.secs, offsetMin); // RULE10
        end
        next_update = localWord;
        if (syncMode >= time_sync_pkg::ModeMasterLo && syncMode <= time_sync_pkg::ModeMasterHi
            && masterTime.valid)
            next_update = masterTime; // RULE9
        if (syncMode == 4'h0 || syncMode > time_sync_pkg::ModeMasterHi || switching)
            next_update.valid = 1'b0; // RULE1 RULE13
    end

    // one second prescaler
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= '0;
            secTick  <= 1'b0;
        end else if (clockEnable) begin
            secTick  <= (prescale == 27'(PrescaleMax));
            prescale <= (prescale == 27'(PrescaleMax)) ? '0 : prescale + 27'h1;
        end
    end

    // minute pulse synchroniser, no filter by design
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulseSync <= 2'h0;
            pulseLast <= 1'b0;
        end else if (clockEnable) begin
            pulseSync <= {pulseSync[0], minutePulse};
            pulseLast <= pulseSync[1];
        end
    end

    // mode change holdoff; a change is treated like start-up
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            modeSeen    <= time_sync_pkg::ModeInternal;
            modeKnown   <= 1'b0;
            switchCount <= '0;
            switching   <= 1'b0;
        end else if (clockEnable) begin
            modeSeen  <= syncMode;
            modeKnown <= 1'b1;
            // the mode present at reset release is the start-up mode, not a change
            if (modeKnown && syncMode != modeSeen) begin
                switching   <= 1'b1; // RULE13
                switchCount <= 27'(time_sync_pkg::SwitchCycles - 1);
            end else if (switching) begin
                switchCount <= switchCount - 27'h1;
                switching   <= (switchCount != 27'h0);
            end
        end
    end

    // the time counter itself
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            systemTime <= '0;
            powerLast  <= 1'b0;
        end else if (clockEnable) begin
            powerLast <= powerGood;
            if ((powerGood && !powerLast) || (!powerGood && rtcTime.valid)) begin
                systemTime <= rtcTime.secs; // RULE2
            end else if (syncMode == time_sync_pkg::ModePulse && pulseEdge) begin
                // RULE7 RULE8
                if (6'(systemTime % time_sync_pkg::SecPerMin) > time_sync_pkg::HalfMinute)
                    systemTime <= systemTime - (systemTime % time_sync_pkg::SecPerMin)
                                  + time_sync_pkg::SecPerMin;
                else
                    systemTime <= systemTime - (systemTime % time_sync_pkg::SecPerMin);
            end else if (next_update.valid) begin
                systemTime <= next_update.secs; // RULE16
            end else if (secTick) begin
                systemTime <= systemTime + 32'h1; // RULE4
            end
        end
    end

    // manual writes go into the battery rtc
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rtcWrite <= '0;
        end else if (clockEnable) begin
            rtcWrite <= manualTime; // RULE3
        end
    end

    // tolerance supervision; caller keeps tolerance at least two minutes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            silentSec <= '0;
            syncState <= time_sync_pkg::SyncLost;
            syncFault <= 1'b0;
        end else if (clockEnable) begin
            if (switching) begin
                syncState <= time_sync_pkg::SyncLost; // RULE13
                silentSec <= '0;
            end else if (next_update.valid ||
                         (syncMode == time_sync_pkg::ModePulse && pulseEdge)) begin
                silentSec <= '0; // RULE16
                syncFault <= 1'b0;
                syncState <= time_sync_pkg::SyncGood;
            end else if (secTick) begin
                if (silentSec != 16'hffff)
                    silentSec <= silentSec + 16'h1;
                if (silentSec >= toleranceSec) begin
                    syncFault <= 1'b1; // RULE11 RULE12
                    syncState <= time_sync_pkg::SyncLost;
                end else if (syncState == time_sync_pkg::SyncLost) begin
                    syncState <= time_sync_pkg::SyncWait;
                end
            end
        end
    end

    assign synced = (syncState == time_sync_pkg::SyncGood);

    // jump reporting: start stamped old, end stamped new
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            jumpEvent   <= '0;
            offsetSeen  <= '0;
            yearSeen    <= '0;
            jumpPending <= 1'b0;
            jumpNewTime <= '0;
        end else if (clockEnable) begin
            jumpEvent.jumpStart <= 1'b0;
            jumpEvent.jumpEnd   <= 1'b0;
            offsetSeen <= offsetMin;
            yearSeen   <= yearBaseSecs;
            if (jumpPending && next_update.valid) begin
                jumpEvent.jumpEnd <= 1'b1; // RULE14 RULE15
                jumpEvent.stamp   <= next_update.secs;
                jumpPending       <= 1'b0;
            end else if ((cfgChange && synced) || (secTick && !syncFault &&
                         silentSec >= toleranceSec && !switching) || (switching &&
                         !jumpPending)) begin
                jumpEvent.jumpStart <= 1'b1; // RULE14 RULE15
                jumpEvent.stamp     <= systemTime;
                jumpPending         <= 1'b1;
            end
        end
    end

endmodule

// file: sim/time_sync_partner.sv
// Purpose: far-side source model, hands over whole decoded time words
// Assumes: bench requests one word at a time
// Notes:   delay 0 answers promptly, larger values model slow decoding
module time_sync_partner (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // request from the bench
    input  wire logic                      go,
    input  wire logic [31:0]               secs,
    input  wire logic [3:0]                delay,
    // decoded word
    output time_sync_pkg::time_word_t      word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       pending;
    logic [3:0] countDown;
    logic [31:0] held;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
            countDown <= 4'h0;
            held <= 32'h0;
            word <= '0;
        end else if (go) begin
            pending <= 1'b1;
            countDown <= delay;
            held <= secs;
            word.valid <= 1'b0;
        end else if (pending && countDown == 4'h0) begin
            pending <= 1'b0;
            word <= {1'b1, held};
        end else begin
            countDown <= countDown - 4'h1;
            // idle word keeps moving so a stale value never looks valid
            word <= {1'b0, ~word.secs};
        end
    end
endmodule

// file: sim/time_sync_source_selector_assertions.sv
// Purpose: port-level checks on the time synchronisation source selector
// Assumes: one clock domain, async active-low reset
// Notes:   mode holdoff is internal, so source acceptance is left to the bench
module time_sync_source_selector_assertions (
    // clock and reset
    input wire logic                       clock,
    input wire logic                       rst_n,
    input wire logic                       clockEnable,
    // inputs
    input wire logic                       powerGood,
    input wire time_sync_pkg::time_word_t  rtcTime,
    input wire time_sync_pkg::time_word_t  manualTime,
    // outputs
    input wire time_sync_pkg::seconds_t    systemTime,
    input wire time_sync_pkg::time_word_t  rtcWrite,
    input wire logic                       syncFault,
    input wire logic                       synced,
    input wire time_sync_pkg::jump_event_t jumpEvent
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_rtc_take;
        rtcTime.valid && !powerGood && clockEnable;
    endsequence
    sequence s_rtc_loaded;
        ##1 systemTime == $past(rtcTime.secs);
    endsequence
    AST_RTC_FIRST: assert property (s_rtc_take |-> s_rtc_loaded)
        else $error("rtc word not loaded during power loss");
    AST_MANUAL_WRITE: assert property (manualTime.valid && clockEnable |=>
        rtcWrite == $past(manualTime))
        else $error("manual set not passed to rtc");
    AST_WRITE_CAUSE: assert property (rtcWrite.valid |-> $past(manualTime.valid))
        else $error("rtc write without manual set");
    AST_FROZEN: assert property (!clockEnable |=> $stable(systemTime))
        else $error("time moved while disabled");
    AST_JUMP_ONE_KIND: assert property (!(jumpEvent.jumpStart && jumpEvent.jumpEnd))
        else $error("jump start and end together");
    AST_JUMP_PULSE: assert property (jumpEvent.jumpStart |=> !jumpEvent.jumpStart)
        else $error("jump start longer than one cycle");
    AST_END_SYNCED: assert property (jumpEvent.jumpEnd |-> synced)
        else $error("jump end without sync");
    AST_FAULT_EXCL: assert property (syncFault |-> !synced)
        else $error("fault while synced");
endmodule

bind time_sync_source_selector time_sync_source_selector_assertions chk (
    .clock(clock), .rst_n(rst_n), .clockEnable(clockEnable), .powerGood(powerGood),
    .rtcTime(rtcTime), .manualTime(manualTime), .systemTime(systemTime),
    .rtcWrite(rtcWrite), .syncFault(syncFault), .synced(synced), .jumpEvent(jumpEvent));

// file: sim/time_sync_source_selector_tb.sv
// Purpose: self-checking bench for the time synchronisation source selector
// Assumes: reset released in mode 1 so no switching holdoff at start
// Notes:   one second holdoff cannot be waited out, only its refusal is seen
module time_sync_source_selector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0]  kind;
        logic        power;
        logic [31:0] secs;
        logic [31:0] want;
    } row_t;
    logic clock = 1'b0, rst_n = 1'b0, clockEnable = 1'b1, powerGood = 1'b1, minutePulse = 1'b0;
    logic [3:0] syncMode = 4'h1;
    logic signed [11:0] offsetMin = 12'sh000;
    logic [31:0] yearBaseSecs = 32'h0, dcfSecs = 32'h0;
    logic [15:0] toleranceSec = 16'h0078;
    logic dcfGo = 1'b0;
    logic [3:0] srcSel = 4'h4;
    logic [31:0] startStamp = 32'h0, endStamp = 32'h0;
    time_sync_pkg::time_word_t rtcTime = '0, manualTime = '0, masterTime = '0, rtcWrite, dcfWord;
    time_sync_pkg::time_word_t srcTime [2:7];
    time_sync_pkg::seconds_t systemTime;
    time_sync_pkg::jump_event_t jumpEvent;
    logic syncFault, synced;
    int n_errors = 0, n_tests = 0, i, k;
    row_t rows [5] = '{
        '{2'h0, 1'b1, 32'h0000_1000, 32'h0000_1000},
        '{2'h0, 1'b0, 32'h0000_2000, 32'h0000_2000},
        '{2'h1, 1'b1, 32'h0000_5555, 32'h0000_2000},
        '{2'h3, 1'b1, 32'h0000_6666, 32'h0000_2000},
        '{2'h2, 1'b1, 32'h0000_3000, 32'h0000_3000}};
    always_comb begin
        for (int j = 2; j <= 7; j++) srcTime[j] = (j == srcSel) ? dcfWord : '0;
    end
    time_sync_partner dcf (.clock(clock), .rst_n(rst_n), .go(dcfGo), .secs(dcfSecs),
        .delay(4'h3), .word(dcfWord));
    // jump pulses last one cycle, so their stamps are latched for later checks
    always @(posedge clock) begin
        if (jumpEvent.jumpStart === 1'b1) startStamp <= jumpEvent.stamp;
        if (jumpEvent.jumpEnd === 1'b1) endStamp <= jumpEvent.stamp;
    end
    time_sync_source_selector uut (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
        .syncMode(syncMode), .offsetMin(offsetMin), .yearBaseSecs(yearBaseSecs),
        .toleranceSec(toleranceSec), .powerGood(powerGood), .rtcTime(rtcTime),
        .manualTime(manualTime), .srcTime(srcTime), .minutePulse(minutePulse),
        .masterTime(masterTime), .systemTime(systemTime), .rtcWrite(rtcWrite),
        .syncFault(syncFault), .synced(synced), .jumpEvent(jumpEvent));
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task test_done;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task pulse(input logic [1:0] kind, input logic [31:0] secs);
        @(posedge clock);
        if (kind == 2'h0) rtcTime <= {1'b1, secs};
        if (kind == 2'h1) dcfSecs <= secs;
        if (kind == 2'h1) dcfGo <= 1'b1;
        if (kind == 2'h2) manualTime <= {1'b1, secs};
        if (kind == 2'h3) masterTime <= {1'b1, secs};
        @(posedge clock);
        rtcTime.valid <= 1'b0;
        manualTime.valid <= 1'b0;
        masterTime.valid <= 1'b0;
        dcfGo <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
    endtask
    task restart(input logic [3:0] mode, input logic [3:0] sel,
                 input logic signed [11:0] offset);
        @(posedge clock);
        rst_n <= 1'b0;
        syncMode <= mode;
        srcSel <= sel;
        offsetMin <= offset;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask
    initial forever #4 clock = ~clock;
    initial begin
        #(8 * 1000);
        n_errors++;
        test_done();
    end
    initial begin
        @(posedge clock);
        #1;
        check(systemTime, 32'h0);
        check({30'h0, syncFault, synced}, 32'h0);
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        for (i = 0; i < 5; i++) begin
            @(posedge clock);
            powerGood <= rows[i].power;
            pulse(rows[i].kind, rows[i].secs);
            check(rows[i].kind == 2'h2 ? rtcWrite.secs : systemTime,
                  rows[i].want);
        end
        check({31'h0, synced}, 32'h1);
        $display("table done");
        @(posedge clock);
        clockEnable <= 1'b0;
        pulse(2'h0, 32'h0000_7777);
        check(systemTime, 32'h0000_2000);
        $display("freeze done");
        @(posedge clock);
        clockEnable <= 1'b1;
        syncMode <= 4'h4;
        k = 0;
        repeat (20) begin
            @(posedge clock);
            #1;
            if (jumpEvent.jumpStart === 1'b1) k = 1;
        end
        check(k, 1);
        check(startStamp, 32'h0000_2000);
        pulse(2'h1, 32'h0000_4444);
        check(systemTime, 32'h0000_2000);
        $display("mode change done");
        // second reset: radio source with a two minute offset
        restart(4'h4, 4'h4, 12'sh002);
        check(systemTime, 32'h0000_7777);
        check({31'h0, synced}, 32'h0);
        pulse(2'h1, 32'h0000_4444);
        check(systemTime, 32'h0000_44bc);
        @(posedge clock);
        offsetMin <= -12'sh001;
        pulse(2'h1, 32'h0000_5000);
        check(startStamp, 32'h0000_44bc);
        check(endStamp, 32'h0000_4fc4);
        check(systemTime, 32'h0000_4fc4);
        check({31'h0, synced}, 32'h1);
        $display("offset done");
        // year base added and offset beyond the limit clamps to 1439 minutes
        @(posedge clock);
        yearBaseSecs <= 32'h0100_0000;
        restart(4'h3, 4'h3, 12'sh5dc);
        pulse(2'h1, 32'h0000_1000);
        check(systemTime, 32'h0101_6144);
        $display("year done");
        restart(4'h6, 4'h4, 12'sh000);
        @(posedge clock);
        minutePulse <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check(systemTime, 32'h0000_7788);
        @(posedge clock);
        minutePulse <= 1'b0;
        powerGood <= 1'b0;
        pulse(2'h0, 32'h0000_1000);
        check(systemTime, 32'h0000_1000);
        @(posedge clock);
        powerGood <= 1'b1;
        minutePulse <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        check(systemTime, 32'h0000_0ff0);
        pulse(2'h1, 32'h0000_4444);
        check(systemTime, 32'h0000_0ff0);
        $display("minute pulse done");
        restart(4'hb, 4'h4, 12'sh000);
        pulse(2'h3, 32'h0000_6000);
        check(systemTime, 32'h0000_6000);
        pulse(2'h1, 32'h0000_4444);
        check(systemTime, 32'h0000_4444);
        $display("master done");
        test_done();
    end
endmodule
